// ---- hw/hcw_logic.sv ----
// Purpose: Interprets the cyclic host control word of a motion unit.
// Assumes: The exchange port, program engine and mapping sources share ref_clk.
// Notes:   Only the unit number strap comes from a pin and is synchronised.
`include "hcw_defines.svh"
`default_nettype none
module hcw_logic (
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Unit number strap pin.
  input  wire logic [3:0]           unit_number,
  // Cyclic exchange word port from the host.
  input  wire logic                 xchg_wr,
  input  wire logic                 xchg_rd,
  input  wire logic [15:0]          xchg_addr,
  input  wire logic [15:0]          xchg_wr_data,
  output logic [15:0]               xchg_rd_data,
  output logic                      xchg_rd_valid,
  // Unit state shown in the status words.
  input  wire logic                 unit_operational,
  input  wire logic [175:0]         status_words_in,
  // Program engine interface.
  input  wire logic                 wd_set_req,
  input  wire logic                 wd_clr_req,
  output logic                      prog_run_enable,
  output logic                      prog_stop_all,
  output logic                      startup_launch,
  output logic                      axes_wd_on,
  output logic                      motion_halt,
  output logic                      motion_buf_clear,
  output logic                      fast_halt,
  // Digital outputs.
  input  wire logic [15:0]          digital_output_array,
  output logic                      dout_array_clear,
  output logic [7:0]                digital_out,
  // Host-routed I/O relay.
  input  wire logic                 scan_tick,
  input  wire logic [15:0]          host_io_in,
  output logic [15:0]               host_io_out,
  // Cyclic mapping setup.
  input  wire logic                 unit_restart,
  input  wire logic                 host_power_cycle,
  input  wire logic                 map_host_wr,
  input  wire logic [15:0]          map_host_cfg,
  input  wire logic                 map_unit_wr,
  input  wire logic [15:0]          map_unit_cfg,
  output logic [15:0]               map_cfg,
  output logic                      map_valid,
  output logic                      map_reject,
  // Message-based table memory write.
  input  wire logic                 msg_table_wr,
  output logic                      table_wr_en
);
  import hcw_pkg::*;

  hcw_state_type state_ff;
  hcw_state_type nxt_state;

  logic [15:0] word_idx;
  logic        in_window;
  logic        wr_ctl;
  logic [3:0]  newc;
  logic [3:0]  oldc;
  logic        rise0;
  logic        fall0;
  logic        rise1;
  logic        fall1;
  logic        rise2;
  logic        map_pick;
  logic [15:0] map_new;
  logic [15:0] first_stat;
  logic [15:0] stat_w [0:12];

  // Window decode relative to the base word of this unit.
  assign word_idx  = xchg_addr - state_ff.base;
  assign in_window = state_ff.strap_done && (xchg_addr >= state_ff.base)
                     && (word_idx < `HCW_NUM_WORDS); // R02

  // Only the control word at the base is writable.
  assign wr_ctl = xchg_wr && in_window
                  && (word_idx[3:0] == `HCW_IDX_CTRL); // R01

  // Edges compare the new word with the previously received one.
  assign newc  = xchg_wr_data[3:0]; // R17
  assign oldc  = state_ff.ctl[3:0]; // R18
  assign rise0 = wr_ctl && newc[`HCW_BIT_RUN] && !oldc[`HCW_BIT_RUN];
  assign fall0 = wr_ctl && !newc[`HCW_BIT_RUN] && oldc[`HCW_BIT_RUN];
  assign rise1 = wr_ctl && newc[`HCW_BIT_WDOG] && !oldc[`HCW_BIT_WDOG];
  assign fall1 = wr_ctl && !newc[`HCW_BIT_WDOG] && oldc[`HCW_BIT_WDOG];
  // Falling bit 2 has no decode at all.
  assign rise2 = wr_ctl && newc[`HCW_BIT_DECEL] && !oldc[`HCW_BIT_DECEL]; // R09

  // First status word: operational, watchdog state and control echo.
  always_comb begin
    first_stat = 16'h0000;
    first_stat[`HCW_STAT_OPER] = unit_operational;
    first_stat[`HCW_STAT_WDON] = state_ff.wd_on;
    first_stat[`HCW_STAT_ECHO_LO +: 4] = state_ff.ctl[3:0]; // R16
  end

  // Word table: control, first status, then the remaining status words.
  assign stat_w[0] = state_ff.ctl;
  assign stat_w[1] = first_stat;
  genvar gi;
  generate
    for (gi = 2; gi < 13; gi = gi + 1) begin : g_stat
      assign stat_w[gi] = status_words_in[(gi-2)*16 +: 16];
    end
  endgenerate

  // Last applied mapping wins; the unit side wins a same-cycle tie.
  assign map_pick = map_unit_wr;
  assign map_new  = map_pick ? map_unit_cfg : map_host_cfg; // R12

  // Next-state logic for the whole block.
  always_comb begin
    nxt_state = state_ff;
    // Strap passes two flops, then is caught once after release.
    // Reset clears the synchroniser, so wait until the second flop holds the pin.
    nxt_state.us1 = unit_number;
    nxt_state.us2 = state_ff.us1;
    if (!state_ff.strap_done) begin
      if (state_ff.strap_wait == 2'h2) begin
        nxt_state.strap_done = 1'b1;
        nxt_state.base = `HCW_BASE_WORD
                         + (`HCW_UNIT_STRIDE * {12'h000, state_ff.us2}); // R01
      end else begin
        nxt_state.strap_wait = state_ff.strap_wait + 2'h1;
      end
    end
    // Pulses default low.
    nxt_state.prog_stop  = 1'b0;
    nxt_state.launch     = 1'b0;
    nxt_state.halt       = 1'b0;
    nxt_state.buf_clr    = 1'b0;
    nxt_state.fast_halt  = 1'b0;
    nxt_state.dout_clr   = 1'b0;
    nxt_state.map_reject = 1'b0;
    nxt_state.rd_valid   = 1'b0;
    // Reads answer one cycle later; outside the window they return zero.
    if (xchg_rd) begin
      nxt_state.rd_valid = 1'b1;
      nxt_state.rd_data  = in_window ? stat_w[word_idx[3:0]] : 16'h0000; // R02
    end
    // Control word capture with full readback.
    if (wr_ctl) begin
      nxt_state.ctl = xchg_wr_data;
    end
    // Programs may run only while bit 0 is high.
    nxt_state.run_en = nxt_state.ctl[`HCW_BIT_RUN]; // R03
    if (fall0) begin
      nxt_state.prog_stop = 1'b1; // R04
      nxt_state.halt      = 1'b1;
      nxt_state.buf_clr   = 1'b1;
      nxt_state.dout_clr  = 1'b1;
    end
    if (rise0) begin
      nxt_state.launch = 1'b1; // R05
    end
    if (fall1) begin
      nxt_state.halt    = 1'b1; // R07
      nxt_state.buf_clr = 1'b1;
    end
    if (rise1) begin
      nxt_state.buf_clr = 1'b1; // R07
    end
    if (rise2) begin
      nxt_state.prog_stop = 1'b1; // R08
      nxt_state.fast_halt = 1'b1;
    end
    // Axes watchdog: programs steer it only while bit 1 allows.
    if (wd_set_req) begin
      nxt_state.wd_on = 1'b1;
    end else if (wd_clr_req) begin
      nxt_state.wd_on = 1'b0;
    end
    if (!nxt_state.ctl[`HCW_BIT_WDOG] || fall0 || fall1) begin
      nxt_state.wd_on = 1'b0; // R06
    end
    // Outputs follow array elements 8 to 15 only while bit 3 is high.
    if (state_ff.ctl[`HCW_BIT_OUTEN] && !fall0) begin
      nxt_state.dout = digital_output_array[15:8]; // R10
    end else begin
      nxt_state.dout = 8'h00; // R10
    end
    // Host-routed I/O is staged one full scan before use.
    if (scan_tick) begin
      nxt_state.io_stage = host_io_in; // R13
      nxt_state.io_out   = state_ff.io_stage; // R13
    end
    // Mapping setup; the table memory area is refused.
    if (map_host_wr || map_unit_wr) begin
      if (map_new[2:0] == `HCW_AREA_TABLE) begin
        nxt_state.map_reject = 1'b1; // R14
      end else begin
        nxt_state.map_cfg   = map_new; // R12
        nxt_state.map_valid = 1'b1;
      end
    end
    // Restart or host power cycle drops the mapping.
    if (unit_restart || host_power_cycle) begin
      nxt_state.map_cfg   = `HCW_MAP_RESET; // R11
      nxt_state.map_valid = 1'b0;
    end
    // Table memory is written only by the message command.
    nxt_state.table_wr = msg_table_wr; // R14
  end

  // State register with constant reset values.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= '0;
      state_ff.ctl <= `HCW_CTRL_RESET;
      state_ff.map_cfg <= `HCW_MAP_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register.
  assign xchg_rd_data     = state_ff.rd_data;
  assign xchg_rd_valid    = state_ff.rd_valid;
  assign prog_run_enable  = state_ff.run_en;
  assign prog_stop_all    = state_ff.prog_stop;
  assign startup_launch   = state_ff.launch;
  assign axes_wd_on       = state_ff.wd_on;
  assign motion_halt      = state_ff.halt;
  assign motion_buf_clear = state_ff.buf_clr;
  assign fast_halt        = state_ff.fast_halt;
  assign dout_array_clear = state_ff.dout_clr;
  assign digital_out      = state_ff.dout;
  assign host_io_out      = state_ff.io_out;
  assign map_cfg          = state_ff.map_cfg;
  assign map_valid        = state_ff.map_valid;
  assign map_reject       = state_ff.map_reject;
  assign table_wr_en      = state_ff.table_wr;

  // Checks on the observable behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_run_gate;
    wr_ctl |=> (prog_run_enable == $past(xchg_wr_data[0]));
  endproperty
  a_run_gate: assert property (p_run_gate) // R03
    else $error("Run enable does not follow bit 0.");

  property p_fall0;
    fall0 |=> (prog_stop_all && motion_halt && motion_buf_clear
               && dout_array_clear && !axes_wd_on && digital_out == 8'h00);
  endproperty
  a_fall0: assert property (p_fall0) // R04
    else $error("Bit 0 fall did not stop everything.");

  property p_rise0;
    rise0 |=> startup_launch ##1 !startup_launch;
  endproperty
  a_rise0: assert property (p_rise0) // R05
    else $error("Bit 0 rise did not launch once.");

  property p_wd_hold;
    !state_ff.ctl[1] |-> !axes_wd_on;
  endproperty
  a_wd_hold: assert property (p_wd_hold) // R06
    else $error("Watchdog on while bit 1 low.");

  property p_rise1;
    (rise1 && !fall0 && !rise2) |=> (motion_buf_clear && !motion_halt);
  endproperty
  a_rise1: assert property (p_rise1) // R07
    else $error("Bit 1 rise must only clear buffers.");

  property p_rise2;
    rise2 |=> (fast_halt && prog_stop_all);
  endproperty
  a_rise2: assert property (p_rise2) // R08
    else $error("Bit 2 rise did not start fast halt.");

  property p_fall2;
    (wr_ctl && oldc[2] && !newc[2] && newc[1:0] == oldc[1:0])
      |=> (!fast_halt && !prog_stop_all && !motion_halt);
  endproperty
  a_fall2: assert property (p_fall2) // R09
    else $error("Bit 2 fall caused an action.");

  property p_out_gate;
    !state_ff.ctl[3] |=> (digital_out == 8'h00);
  endproperty
  a_out_gate: assert property (p_out_gate) // R10
    else $error("Outputs not forced off.");

  property p_echo;
    (xchg_rd && in_window && word_idx[3:0] == `HCW_IDX_STAT)
      |=> (xchg_rd_valid && xchg_rd_data[11:8] == $past(state_ff.ctl[3:0]));
  endproperty
  a_echo: assert property (p_echo) // R16
    else $error("Status echo wrong.");

  property p_io_stage;
    scan_tick |=> (host_io_out == $past(state_ff.io_stage));
  endproperty
  a_io_stage: assert property (p_io_stage) // R13
    else $error("Host I/O not delayed by one scan.");

  property p_restart;
    (unit_restart || host_power_cycle) |=> (!map_valid && map_cfg == 16'h0000);
  endproperty
  a_restart: assert property (p_restart) // R11
    else $error("Mapping kept across restart.");

  property p_map_last;
    (map_host_wr && !map_unit_wr && map_host_cfg[2:0] != 3'h7
     && !unit_restart && !host_power_cycle) |=> (map_cfg == $past(map_host_cfg));
  endproperty
  a_map_last: assert property (p_map_last) // R12
    else $error("Latest mapping did not replace earlier.");

  property p_table;
    ((map_host_wr || map_unit_wr) && map_new[2:0] == 3'h7
     && !unit_restart && !host_power_cycle)
      |=> (map_reject && $stable(map_cfg));
  endproperty
  a_table: assert property (p_table) // R14
    else $error("Table memory was mapped.");
endmodule
`default_nettype wire

// ---- hw/hcw_defines.svh ----
// Purpose: Constants for the host control word logic.
// Assumes: Control and status words are 16 bits wide.
// Notes:   Offsets are word indices relative to the exchange base word.
// Summary of operation
// R01 - Base word is 1500 plus 25 times unit
// R02 - Thirteen consecutive control and status words provided
// R03 - Bit 0 low blocks all stored programs
// R04 - Bit 0 fall stops everything, clears outputs
// R05 - Bit 0 rise launches power-up programs
// R06 - Bit 1 low holds axes watchdog off
// R07 - Bit 1 fall halts; rise empties buffers
// R08 - Bit 2 rise stops programs, fast halt
// R09 - Bit 2 fall does nothing
// R10 - Bit 3 gates outputs from array 8-15
// R11 - Mapping lost on restart or power cycle
// R12 - Latest mapping configuration fully replaces earlier
// R13 - Host-routed I/O adds one host scan
// R14 - Table memory excluded from cyclic mapping
// R15 - Host should set mapping at startup
// R16 - Status word bits 8-11 echo control
// R17 - Control bits 4-15 ignored by unit
// R18 - Edges found against previous received word
`ifndef HCW_DEFINES_SVH
`define HCW_DEFINES_SVH
`define HCW_BASE_WORD    16'h05DC
`define HCW_UNIT_STRIDE  16'h0019
`define HCW_NUM_WORDS    16'h000D
`define HCW_IDX_CTRL     4'h0
`define HCW_IDX_STAT     4'h1
`define HCW_BIT_RUN      0
`define HCW_BIT_WDOG     1
`define HCW_BIT_DECEL    2
`define HCW_BIT_OUTEN    3
`define HCW_STAT_OPER    0
`define HCW_STAT_WDON    1
`define HCW_STAT_ECHO_LO 8
`define HCW_AREA_TABLE   3'h7
`define HCW_CTRL_RESET   16'h0000
`define HCW_MAP_RESET    16'h0000
`endif

// ---- hw/hcw_pkg.sv ----
// Purpose: Types for the host control word logic.
// Assumes: Constants come from the defines header.
// Notes:   The whole module state is one packed struct.
`default_nettype none
package hcw_pkg;
  typedef struct packed {
    logic [3:0]  us1;
    logic [3:0]  us2;
    logic        strap_done;
    logic [1:0]  strap_wait;
    logic [15:0] base;
    logic [15:0] ctl;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        run_en;
    logic        wd_on;
    logic        prog_stop;
    logic        launch;
    logic        halt;
    logic        buf_clr;
    logic        fast_halt;
    logic        dout_clr;
    logic [7:0]  dout;
    logic [15:0] io_stage;
    logic [15:0] io_out;
    logic [15:0] map_cfg;
    logic        map_valid;
    logic        map_reject;
    logic        table_wr;
  } hcw_state_type;
endpackage
`default_nettype wire

// ---- sim/hcw_host_model.sv ----
// Purpose: Behavioural host controller that scans the unit and relays its inputs.
// Assumes: One host scan every eight ref_clk cycles is enough to exercise the relay.
// Notes:   Each scan presents a new input word, so a stale relay shows at once.
`default_nettype none
module hcw_host_model (
  // Clock and reset.
  input  wire logic   ref_clk,
  input  wire logic   reset,
  // Scan marker and relayed inputs toward the unit.
  output logic        scan_tick,
  output logic [15:0] host_io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] scan_cnt;
  // A scan is raised for one cycle every eight, and a fresh input word goes with it.
  always @(negedge ref_clk or posedge reset) begin
    if (reset) begin
      scan_cnt   <= 3'h0;
      scan_tick  <= 1'b0;
      host_io_in <= 16'h0000;
    end else begin
      scan_cnt  <= scan_cnt + 3'h1;
      scan_tick <= (scan_cnt == 3'h7);
      if (scan_cnt == 3'h7) begin
        host_io_in <= host_io_in + 16'h0101;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/test_host_control_word_logic.sv ----
// Purpose: Self-checking bench for the host control word logic.
// Assumes: Unit number 2, so the exchange area starts at word 1550.
// Notes:   Pulses are gathered over two cycles so either edge alignment is seen.
`default_nettype none
module test_host_control_word_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BASE = 16'h060E; // Word 1500 plus 25 times unit 2.
  logic        ref_clk, reset, xchg_wr, xchg_rd, xchg_rd_valid, unit_operational;
  logic        wd_set_req, wd_clr_req, prog_run_enable, prog_stop_all, startup_launch;
  logic        axes_wd_on, motion_halt, motion_buf_clear, fast_halt, dout_array_clear;
  logic        scan_tick, unit_restart, host_power_cycle, map_host_wr, map_unit_wr;
  logic        map_valid, map_reject, msg_table_wr, table_wr_en, rej;
  logic [3:0]  unit_number;
  logic [5:0]  pulses;
  logic [7:0]  digital_out;
  logic [15:0] xchg_addr, xchg_wr_data, xchg_rd_data, digital_output_array, v;
  logic [15:0] host_io_in, host_io_out, map_host_cfg, map_unit_cfg, map_cfg;
  logic [175:0] status_words_in;
  int          mismatches, num_checks;
  // Control pulses gathered into one vector for the write task.
  assign pulses = {prog_stop_all, startup_launch, motion_halt, motion_buf_clear,
                   fast_halt, dout_array_clear};
  hcw_logic dut_u (.ref_clk, .reset, .unit_number, .xchg_wr, .xchg_rd, .xchg_addr,
    .xchg_wr_data, .xchg_rd_data, .xchg_rd_valid, .unit_operational, .status_words_in,
    .wd_set_req, .wd_clr_req, .prog_run_enable, .prog_stop_all, .startup_launch,
    .axes_wd_on, .motion_halt, .motion_buf_clear, .fast_halt, .digital_output_array,
    .dout_array_clear, .digital_out, .scan_tick, .host_io_in, .host_io_out, .unit_restart,
    .host_power_cycle, .map_host_wr, .map_host_cfg, .map_unit_wr, .map_unit_cfg, .map_cfg,
    .map_valid, .map_reject, .msg_table_wr, .table_wr_en);
  hcw_host_model host_u (.ref_clk, .reset, .scan_tick, .host_io_in);
  // Free-running 200 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compares one value and reports a difference at once.
  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Writes one exchange word and compares the control pulses it causes.
  task automatic wrc(input logic [15:0] a, input logic [15:0] d, input logic [5:0] exp);
    logic [5:0] p;
    xchg_addr = a;
    xchg_wr_data = d;
    xchg_wr = 1'b1;
    p = 6'h00;
    @(negedge ref_clk);
    xchg_wr = 1'b0;
    repeat (2) begin
      p = p | pulses;
      @(negedge ref_clk);
    end
    check({12'h000, p}, {12'h000, exp}, "control pulses");
  endtask
  // Reads one exchange word, waiting a bounded time for the answer.
  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    int n;
    xchg_addr = a;
    xchg_rd = 1'b1;
    @(negedge ref_clk);
    xchg_rd = 1'b0;
    n = 0;
    while (xchg_rd_valid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    check({2'h0, xchg_rd_data}, {2'h0, exp}, "read data");
    if (n == 4) begin
      mismatches++;
      conclude();
    end
    @(negedge ref_clk);
  endtask
  // Applies one mapping request and compares valid, refusal and the held setup.
  task automatic mp(input logic unit, input logic [15:0] cfg, input logic [17:0] exp);
    map_host_cfg = cfg;
    map_unit_cfg = cfg;
    map_host_wr = !unit;
    map_unit_wr = unit;
    @(negedge ref_clk);
    map_host_wr = 1'b0;
    map_unit_wr = 1'b0;
    rej = map_reject;
    @(negedge ref_clk);
    check({map_valid, rej | map_reject, map_cfg}, exp, "mapping");
  endtask
  // Requests the watchdog on or off from a program and compares the result.
  task automatic wdc(input logic clr, input logic exp);
    wd_set_req = !clr;
    wd_clr_req = clr;
    @(negedge ref_clk);
    wd_set_req = 1'b0;
    wd_clr_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({17'h0, axes_wd_on}, {17'h0, exp}, "axes watchdog");
  endtask
  // Main sequence.
  initial begin
    {xchg_wr, xchg_rd, wd_set_req, wd_clr_req, unit_restart, host_power_cycle} = 6'h00;
    {map_host_wr, map_unit_wr, msg_table_wr, mismatches, num_checks} = '0;
    {xchg_addr, xchg_wr_data, map_host_cfg, map_unit_cfg} = '0;
    unit_number = 4'h2;
    unit_operational = 1'b1;
    status_words_in = {16'hBEEF, 160'h0};
    digital_output_array = 16'hA55A;
    reset = 1'b1;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    mp(1'b0, 16'h0011, 18'h20011);
    mp(1'b1, 16'h0022, 18'h20022);
    mp(1'b0, 16'h0037, 18'h30022);
    wrc(BASE, 16'h0001, 6'h10);
    wdc(1'b0, 1'b0);
    wrc(BASE, 16'h0003, 6'h04);
    wdc(1'b0, 1'b1);
    wdc(1'b1, 1'b0);
    wdc(1'b0, 1'b1);
    wrc(BASE, 16'h0001, 6'h0C);
    check({17'h0, axes_wd_on}, 18'h0, "watchdog after fall");
    wrc(BASE, 16'h0009, 6'h00);
    check({10'h0, digital_out}, 18'h000A5, "outputs enabled");
    wrc(BASE, 16'h000D, 6'h22);
    rdc(BASE + 16'h0001, 16'h0D01);
    wrc(BASE, 16'h0009, 6'h00);
    wrc(BASE, 16'hFFF9, 6'h00);
    rdc(BASE, 16'hFFF9);
    wrc(BASE, 16'h0008, 6'h2D);
    check({17'h0, prog_run_enable}, 18'h0, "programs blocked");
    wrc(BASE, 16'h0000, 6'h00);
    check({10'h0, digital_out}, 18'h0, "outputs forced off");
    wrc(BASE + 16'h0001, 16'h0001, 6'h00);
    check({17'h0, prog_run_enable}, 18'h0, "status word not writable");
    rdc(BASE + 16'h000C, 16'hBEEF);
    rdc(BASE + 16'h000D, 16'h0000);
    rdc(BASE - 16'h0001, 16'h0000);
    unit_restart = 1'b1;
    @(negedge ref_clk);
    unit_restart = 1'b0;
    @(negedge ref_clk);
    check({17'h0, map_valid}, 18'h0, "mapping after restart");
    mp(1'b1, 16'h0044, 18'h20044);
    host_power_cycle = 1'b1;
    @(negedge ref_clk);
    host_power_cycle = 1'b0;
    @(negedge ref_clk);
    check({17'h0, map_valid}, 18'h0, "mapping after power cycle");
    msg_table_wr = 1'b1;
    @(negedge ref_clk);
    msg_table_wr = 1'b0;
    rej = table_wr_en;
    @(negedge ref_clk);
    check({17'h0, rej | table_wr_en}, 18'h1, "table write");
    repeat (3) begin
      for (int n = 0; n < 20 && scan_tick !== 1'b1; n++) @(negedge ref_clk);
      if (scan_tick !== 1'b1) begin
        mismatches++;
        conclude();
      end
      v = host_io_in;
      @(negedge ref_clk);
      check({2'h0, host_io_out}, {2'h0, v - 16'h0101}, "host relay");
    end
    conclude();
  end
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
